// file: core/frt_cc_pkg.sv
// package for the two-unit free-running capture/compare timer
// assumes a single 125 MHz clock and plain control ports, no register bus
package frt_cc_pkg;
   localparam int CNT_W     = 16;
   localparam int N_UNIT    = 2;
   localparam int N_CAP     = 2;
   localparam int N_CMP     = 8;
   localparam int UNIT0_CMP = 4;
   localparam int PRE_W     = 8;
   // prescale select codes: 0 -> /4, 1 -> /16, 2 -> /64, 3 -> /256
   localparam logic [1:0] DIV4   = 2'h0;
   localparam logic [1:0] DIV16  = 2'h1;
   localparam logic [1:0] DIV64  = 2'h2;
   localparam logic [1:0] DIV256 = 2'h3;
   localparam logic [PRE_W-1:0] MASK4   = 8'h03;
   localparam logic [PRE_W-1:0] MASK16  = 8'h0F;
   localparam logic [PRE_W-1:0] MASK64  = 8'h3F;
   localparam logic [PRE_W-1:0] MASK256 = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

   typedef enum logic [1:0] {
      EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH
   } edge_sel_t;

   // per-unit control bundle
   typedef struct packed {
      logic [1:0] prescale_sel;
      logic       counter_clear_bit;
      logic       ovf_xfer_sel;
   } unit_ctrl_t;

   // per-compare control bundle
   typedef struct packed {
      logic [CNT_W-1:0] value;
      logic             enable;
      logic             init_load;
      logic             init_level;
      logic             xfer_sel;
   } cmp_ctrl_t;
endpackage

// file: core/freerun_capture_compare_timer.sv
// two-unit free-running timer with input capture and output compare
// assumes trigger pins are asynchronous; control ports come from the
// same clock domain; interrupt outputs are level requests held until ack
module freerun_capture_compare_timer
   import frt_cc_pkg::*;
(
   // clock and reset
   input  wire logic                         i_clk,
   input  wire logic                         i_resetn,
   // unit control
   input  wire frt_cc_pkg::unit_ctrl_t [1:0] i_unit_ctrl,
   input  wire logic [1:0]                   i_ovf_ack,
   // capture control and pins
   input  wire frt_cc_pkg::edge_sel_t [1:0]  i_cap_edge,
   input  wire logic [1:0]                   i_cap_xfer_sel,
   input  wire logic [1:0]                   i_cap_ack,
   input  wire logic                         i_capture0_trigger_pin_a,
   input  wire logic                         i_capture0_trigger_pin_b,
   input  wire logic                         i_capture1_trigger_pin_a,
   input  wire logic                         i_capture1_trigger_pin_b,
   // compare control
   input  wire frt_cc_pkg::cmp_ctrl_t [7:0]  i_cmp_ctrl,
   input  wire logic [7:0]                   i_cmp_ack,
   // counter and capture values
   output logic [1:0][15:0]                  o_count,
   output logic [1:0][15:0]                  o_cap_value,
   // compare pins
   output logic [7:0]                        o_cmp_pin,
   // requests: cpu interrupt or transfer service
   output logic [1:0]                        o_ovf_irq,
   output logic [1:0]                        o_ovf_xfer_req,
   output logic [1:0]                        o_cap_irq,
   output logic [1:0]                        o_cap_xfer_req,
   output logic [7:0]                        o_cmp_irq,
   output logic [7:0]                        o_cmp_xfer_req
);
   import frt_cc_pkg::*;

   // ***********************************************************
   // reset release
   // ***********************************************************
   logic [1:0] rst_sync_ff;
   logic       rst_n;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ***********************************************************
   // pin synchronisers and edge detection
   // ***********************************************************
   // both pins of a channel always feed it; no per-pin mask exists
   logic [1:0] pin_mix;
   assign pin_mix[0] = i_capture0_trigger_pin_a ^ i_capture0_trigger_pin_b;
   assign pin_mix[1] = i_capture1_trigger_pin_a ^ i_capture1_trigger_pin_b;

   logic [1:0][2:0] sync_ff;
   logic [1:0][2:0] nxt_sync;
   logic [1:0]      lvl_ff;
   logic [1:0]      nxt_lvl;
   logic [1:0]      cap_hit;
   always_comb begin
      for (int c = 0; c < N_CAP; c++) begin
         nxt_sync[c] = {sync_ff[c][1:0], pin_mix[c]};
         nxt_lvl[c]  = lvl_ff[c];
         cap_hit[c]  = 1'b0;
         // a change counts once stages two and three agree
         if (sync_ff[c][1] == sync_ff[c][2] && sync_ff[c][2] != lvl_ff[c]) begin
            nxt_lvl[c] = sync_ff[c][2];
            case (i_cap_edge[c])
               EDGE_RISE: cap_hit[c] = sync_ff[c][2];
               EDGE_FALL: cap_hit[c] = ~sync_ff[c][2];
               EDGE_BOTH: cap_hit[c] = 1'b1;
               default:   cap_hit[c] = 1'b0;
            endcase
         end
      end
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_ff <= '0;
         lvl_ff  <= 2'h0;
      end else begin
         sync_ff <= nxt_sync;
         lvl_ff  <= nxt_lvl;
      end
   end

   // ***********************************************************
   // prescalers and free-running counters
   // ***********************************************************
   logic [1:0][PRE_W-1:0] pre_ff;
   logic [1:0][PRE_W-1:0] nxt_pre;
   logic [1:0][CNT_W-1:0] cnt_ff;
   logic [1:0][CNT_W-1:0] nxt_cnt;
   logic [1:0]            ovf_ev;
   logic [1:0]            unit_match;
   logic [7:0]            cmp_match;

   always_comb begin
      unit_match[0] = 1'b0;
      unit_match[1] = 1'b0;
      for (int k = 0; k < N_CMP; k++) begin
         if (k < UNIT0_CMP) unit_match[0] = unit_match[0] | cmp_match[k];
         else               unit_match[1] = unit_match[1] | cmp_match[k];
      end
   end

   always_comb begin
      logic [PRE_W-1:0] mask;
      mask = MASK4;
      for (int u = 0; u < N_UNIT; u++) begin
         case (i_unit_ctrl[u].prescale_sel)
            DIV4:    mask = MASK4;
            DIV16:   mask = MASK16;
            DIV64:   mask = MASK64;
            default: mask = MASK256;
         endcase
         nxt_pre[u] = pre_ff[u] + 8'h01;
         nxt_cnt[u] = cnt_ff[u];
         ovf_ev[u]  = 1'b0;
         if (i_unit_ctrl[u].counter_clear_bit || unit_match[u]) begin
            // clear also restarts the prescaler for a clean first tick
            nxt_cnt[u] = CNT_RST;
            nxt_pre[u] = 8'h00;
         end else if ((pre_ff[u] & mask) == mask) begin
            nxt_cnt[u] = cnt_ff[u] + 16'h0001;
            ovf_ev[u]  = (cnt_ff[u] == CNT_MAX);
         end
      end
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_ff <= '0;
         cnt_ff <= '0;
      end else begin
         pre_ff <= nxt_pre;
         cnt_ff <= nxt_cnt;
      end
   end

   // ***********************************************************
   // capture registers
   // ***********************************************************
   logic [1:0][CNT_W-1:0] cap_ff;
   logic [1:0][CNT_W-1:0] nxt_cap;
   always_comb begin
      for (int c = 0; c < N_CAP; c++) begin
         // both captures belong to unit 0's time base
         nxt_cap[c] = cap_hit[c] ? cnt_ff[0] : cap_ff[c];
      end
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_ff <= '0;
      end else begin
         cap_ff <= nxt_cap;
      end
   end

   // ***********************************************************
   // compare channels
   // ***********************************************************
   logic [7:0] pin_ff;
   logic [7:0] nxt_pin;
   logic [7:0] match_seen_ff;
   logic [7:0] nxt_match_seen;
   genvar g;
   generate
      for (g = 0; g < N_CMP; g++) begin : g_cmp
         localparam int U = (g < UNIT0_CMP) ? 0 : 1;
         // match fires once per equal period, not every clock of it
         assign cmp_match[g] = i_cmp_ctrl[g].enable
                             && (cnt_ff[U] == i_cmp_ctrl[g].value)
                             && !match_seen_ff[g];
         always_comb begin
            nxt_match_seen[g] = i_cmp_ctrl[g].enable
                             && (cnt_ff[U] == i_cmp_ctrl[g].value);
            if (i_cmp_ctrl[g].init_load) begin
               nxt_pin[g] = i_cmp_ctrl[g].init_level;
            end else begin
               nxt_pin[g] = pin_ff[g] ^ cmp_match[g];
            end
         end
      end
   endgenerate
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_ff        <= 8'h00;
         match_seen_ff <= 8'h00;
      end else begin
         pin_ff        <= nxt_pin;
         match_seen_ff <= nxt_match_seen;
      end
   end

   // ***********************************************************
   // request flags: set wins over acknowledge
   // ***********************************************************
   logic [1:0] ovf_flag_ff;
   logic [1:0] nxt_ovf_flag;
   logic [1:0] cap_flag_ff;
   logic [1:0] nxt_cap_flag;
   logic [7:0] cmp_flag_ff;
   logic [7:0] nxt_cmp_flag;
   logic [1:0] ovf_xsel;
   logic [7:0] cmp_xsel;
   always_comb begin
      nxt_ovf_flag = ovf_ev | (ovf_flag_ff & ~i_ovf_ack);
      nxt_cap_flag = cap_hit | (cap_flag_ff & ~i_cap_ack);
      nxt_cmp_flag = cmp_match | (cmp_flag_ff & ~i_cmp_ack);
      for (int u = 0; u < N_UNIT; u++) begin
         ovf_xsel[u] = i_unit_ctrl[u].ovf_xfer_sel;
      end
      for (int k = 0; k < N_CMP; k++) begin
         cmp_xsel[k] = i_cmp_ctrl[k].xfer_sel;
      end
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_flag_ff <= 2'h0;
         cap_flag_ff <= 2'h0;
         cmp_flag_ff <= 8'h00;
      end else begin
         ovf_flag_ff <= nxt_ovf_flag;
         cap_flag_ff <= nxt_cap_flag;
         cmp_flag_ff <= nxt_cmp_flag;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   // requests are registered from the next flag values, so they move
   // on the same edge as the flags; the route select is applied on that same edge
   assign o_count        = cnt_ff;
   assign o_cap_value    = cap_ff;
   assign o_cmp_pin      = pin_ff;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_ovf_irq      <= 2'h0;
         o_ovf_xfer_req <= 2'h0;
         o_cap_irq      <= 2'h0;
         o_cap_xfer_req <= 2'h0;
         o_cmp_irq      <= 8'h00;
         o_cmp_xfer_req <= 8'h00;
      end else begin
         o_ovf_irq      <= nxt_ovf_flag & ~ovf_xsel;
         o_ovf_xfer_req <= nxt_ovf_flag & ovf_xsel;
         o_cap_irq      <= nxt_cap_flag & ~i_cap_xfer_sel;
         o_cap_xfer_req <= nxt_cap_flag & i_cap_xfer_sel;
         o_cmp_irq      <= nxt_cmp_flag & ~cmp_xsel;
         o_cmp_xfer_req <= nxt_cmp_flag & cmp_xsel;
      end
   end
endmodule

// file: dv/frt_cc_trig_src.sv
// external trigger pin source for the capture channels
// assumes the bench calls toggle() just after a falling clock edge
module frt_cc_trig_src (
   // clock
   input  wire logic       i_clk,
   // pins in order c0a, c0b, c1a, c1b
   output logic      [3:0] o_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // source
   // ****
   initial o_pins = 4'h0;
   // a slow source lets d cycles pass before its edge
   task automatic toggle(input int k, input int d);
      repeat (d) @(negedge i_clk);
      o_pins[k] = ~o_pins[k];
   endtask
endmodule

// file: dv/freerun_capture_compare_timer_chk.sv
// port checker for the capture/compare timer, bound to its top module
// assumes the package is compiled first
module freerun_capture_compare_timer_chk
   import frt_cc_pkg::*;
(
   // clock and reset
   input wire logic                         i_clk,
   input wire logic                         i_resetn,
   // controls and pins
   input wire frt_cc_pkg::unit_ctrl_t [1:0] i_unit_ctrl,
   input wire frt_cc_pkg::edge_sel_t [1:0]  i_cap_edge,
   input wire logic                         i_capture0_trigger_pin_a,
   input wire logic                         i_capture0_trigger_pin_b,
   input wire frt_cc_pkg::cmp_ctrl_t [7:0]  i_cmp_ctrl,
   input wire logic [7:0]                   i_cmp_ack,
   // watched outputs
   input wire logic [1:0][15:0]             o_count,
   input wire logic [7:0]                   o_cmp_pin,
   input wire logic [1:0]                   o_ovf_irq,
   input wire logic [1:0]                   o_ovf_xfer_req,
   input wire logic [1:0]                   o_cap_irq,
   input wire logic [1:0]                   o_cap_xfer_req,
   input wire logic [7:0]                   o_cmp_irq,
   input wire logic [7:0]                   o_cmp_xfer_req
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   a_clear_zero: assert property (i_unit_ctrl[0].counter_clear_bit
      |=> o_count[0] == 16'h0000) else $error("count not cleared");
   a_count_step: assert property (!$stable(o_count[0])
      |-> (o_count[0] - $past(o_count[0])) == 16'h0001
      || o_count[0] == 16'h0000) else $error("count jumped");
   a_ovf_wrap: assert property ($past(o_count[0]) == 16'hFFFF
      && o_count[0] == 16'h0000 |-> (o_ovf_irq[0] | o_ovf_xfer_req[0]))
      else $error("no overflow request");
   a_cap_edge: assert property (i_cap_edge[0] == EDGE_BOTH
      && $changed(i_capture0_trigger_pin_a ^ i_capture0_trigger_pin_b)
      |-> ##[2:5] (o_cap_irq[0] | o_cap_xfer_req[0]))
      else $error("edge not captured");
   a_cmp_match: assert property (i_cmp_ctrl[0].enable
      && $changed(o_count[0]) && o_count[0] == i_cmp_ctrl[0].value
      |=> $changed(o_cmp_pin[0]) && o_count[0] == 16'h0000)
      else $error("match did not toggle and clear");
   a_cmp_off: assert property (!i_cmp_ctrl[4].enable
      && !i_cmp_ctrl[4].init_load |=> $stable(o_cmp_pin[4]))
      else $error("idle pin moved");
   a_init_load: assert property (i_cmp_ctrl[4].init_load
      |=> o_cmp_pin[4] == $past(i_cmp_ctrl[4].init_level))
      else $error("initial level not loaded");
   a_flag_stands: assert property ((o_cmp_irq[0] | o_cmp_xfer_req[0])
      && !i_cmp_ack[0] |=> (o_cmp_irq[0] | o_cmp_xfer_req[0]))
      else $error("request dropped without ack");
endmodule

bind freerun_capture_compare_timer freerun_capture_compare_timer_chk u_chk (
   .i_clk, .i_resetn, .i_unit_ctrl, .i_cap_edge, .i_capture0_trigger_pin_a,
   .i_capture0_trigger_pin_b, .i_cmp_ctrl, .i_cmp_ack, .o_count, .o_cmp_pin,
   .o_ovf_irq, .o_ovf_xfer_req, .o_cap_irq, .o_cap_xfer_req, .o_cmp_irq,
   .o_cmp_xfer_req
);

// file: dv/freerun_capture_compare_timer_tb_top.sv
// bench for the capture/compare timer with a capture scoreboard
// assumes package, trigger source and checker are compiled first
module freerun_capture_compare_timer_tb_top
   import frt_cc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  i_clk;
   logic                  i_resetn;
   unit_ctrl_t [1:0]      i_unit_ctrl;
   edge_sel_t [1:0]       i_cap_edge;
   cmp_ctrl_t [7:0]       i_cmp_ctrl;
   logic [1:0]            i_ovf_ack, i_cap_xfer_sel, i_cap_ack;
   logic [7:0]            i_cmp_ack, o_cmp_pin, o_cmp_irq, o_cmp_xfer_req;
   logic [1:0][15:0]      o_count, o_cap_value;
   logic [1:0]            o_ovf_irq, o_ovf_xfer_req, o_cap_irq, o_cap_xfer_req;
   logic [1:0]            prev_f = 2'h0;
   wire logic [3:0]       pins;
   logic [15:0]           capq [2][$];
   int                    bad_count = 0, n_compared = 0, seed = 65611;
   int                    cyc = 0, t0 = 0;
   // ****
   // design and source
   // ****
   frt_cc_trig_src u_src (.i_clk(i_clk), .o_pins(pins));
   freerun_capture_compare_timer DUT (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_unit_ctrl(i_unit_ctrl), .i_ovf_ack(i_ovf_ack),
      .i_cap_edge(i_cap_edge), .i_cap_xfer_sel(i_cap_xfer_sel),
      .i_cap_ack(i_cap_ack), .i_capture0_trigger_pin_a(pins[0]),
      .i_capture0_trigger_pin_b(pins[1]), .i_capture1_trigger_pin_a(pins[2]),
      .i_capture1_trigger_pin_b(pins[3]), .i_cmp_ctrl(i_cmp_ctrl),
      .i_cmp_ack(i_cmp_ack), .o_count(o_count), .o_cap_value(o_cap_value),
      .o_cmp_pin(o_cmp_pin), .o_ovf_irq(o_ovf_irq),
      .o_ovf_xfer_req(o_ovf_xfer_req), .o_cap_irq(o_cap_irq),
      .o_cap_xfer_req(o_cap_xfer_req), .o_cmp_irq(o_cmp_irq),
      .o_cmp_xfer_req(o_cmp_xfer_req));
   // ****
   // tasks
   // ****
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      i_resetn = 1'b0;
      repeat (12) @(negedge i_clk);
      i_resetn = 1'b1;
      repeat (4) @(negedge i_clk);
   endtask
   task automatic clr(input int u);
      i_unit_ctrl[u].counter_clear_bit = 1'b1;
      @(negedge i_clk);
      i_unit_ctrl[u].counter_clear_bit = 1'b0;
      t0 = cyc;
   endtask
   // ****
   // clock, watchdog, capture monitor
   // ****
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   always @(posedge i_clk) cyc <= cyc + 1;
   // whole run is some 10k cycles; overflow needs 262k, so only checked
   initial begin
      #400000;
      bad_count++;
      conclude();
   end
   always @(posedge i_clk) begin
      for (int c = 0; c < 2; c++) begin
         if ((o_cap_irq[c] | o_cap_xfer_req[c]) && !prev_f[c]) begin
            chk(capq[c].size() > 0, 1);
            if (capq[c].size() > 0) chk(o_cap_value[c], capq[c].pop_front());
            chk(o_cap_xfer_req[c], i_cap_xfer_sel[c]);
         end
      end
      prev_f <= o_cap_irq | o_cap_xfer_req;
   end
   // ****
   // main sequence
   // ****
   initial begin
      int m, j, k, ch, v, r, n;
      logic nw;
      logic [7:0] pin_exp;
      edge_sel_t md;
      i_resetn = 1'b0;
      i_unit_ctrl = '0;
      i_cap_edge[0] = EDGE_OFF;
      i_cap_edge[1] = EDGE_OFF;
      {i_ovf_ack, i_cap_xfer_sel, i_cap_ack, i_cmp_ack} = 14'h0;
      i_cmp_ctrl = '0;
      pin_exp = 8'h00;
      do_reset();
      chk(o_count, 32'h0);
      for (m = 0; m < 4; m++) begin
         i_unit_ctrl[1].prescale_sel = m[1:0];
         clr(1);
         repeat (5 * (4 << 2 * m) + (2 << 2 * m)) @(negedge i_clk);
         chk(o_count[1], 32'h5);
      end
      i_unit_ctrl[0].prescale_sel = DIV256;
      clr(0);
      for (m = 0; m < 4; m++) begin
         i_cap_edge[0] = edge_sel_t'(m);
         i_cap_edge[1] = edge_sel_t'(3 - m);
         i_cap_xfer_sel = 2'($random(seed));
         for (j = 0; j < 6; j++) begin
            k = (j < 4) ? j : {$random(seed)} % 4;
            // mid-tick edges keep the expected count clear of tick phase
            while ((cyc - t0) % 256 != 128) @(negedge i_clk);
            ch = k / 2;
            nw = ~(pins[2 * ch] ^ pins[2 * ch + 1]);
            md = i_cap_edge[ch];
            if (md == EDGE_BOTH || (md == EDGE_RISE && nw)
                || (md == EDGE_FALL && !nw)) begin
               capq[ch].push_back(16'((cyc - t0) / 256));
            end
            u_src.toggle(k, {$random(seed)} % 3);
            repeat (10) @(negedge i_clk);
            i_cap_ack = 2'h3;
            @(negedge i_clk);
            i_cap_ack = 2'h0;
         end
      end
      chk(capq[0].size() + capq[1].size(), 32'h0);
      i_cap_edge[0] = EDGE_OFF;
      i_cap_edge[1] = EDGE_OFF;
      for (k = 0; k < 8; k++) begin
         i_unit_ctrl[k / 4].prescale_sel = DIV4;
         v = 3 + {$random(seed)} % 40;
         pin_exp[k] = 1'($random(seed));
         i_cmp_ctrl[k].init_level = pin_exp[k];
         i_cmp_ctrl[k].init_load = 1'b1;
         @(negedge i_clk);
         i_cmp_ctrl[k].init_load = 1'b0;
         chk(o_cmp_pin, pin_exp);
         i_cmp_ctrl[k].value = 16'(v);
         i_cmp_ctrl[k].xfer_sel = 1'($random(seed));
         clr(k / 4);
         i_cmp_ctrl[k].enable = 1'b1;
         for (r = 0; r < 2; r++) begin
            n = 0;
            while ((o_cmp_irq[k] | o_cmp_xfer_req[k]) !== 1'b1 && n < 1000) begin
               @(negedge i_clk);
               n++;
            end
            if (r == 0) chk(n > 4 * v - 3 && n < 4 * v + 4, 1);
            pin_exp[k] = ~pin_exp[k];
            chk(o_cmp_pin, pin_exp);
            chk(o_cmp_irq | o_cmp_xfer_req, 8'h1 << k);
            chk(o_cmp_xfer_req[k], i_cmp_ctrl[k].xfer_sel);
            i_cmp_ack[k] = 1'b1;
            @(negedge i_clk);
            i_cmp_ack[k] = 1'b0;
         end
         i_cmp_ctrl[k].enable = 1'b0;
      end
      // counters never reach all-ones in this short run
      chk(o_ovf_irq | o_ovf_xfer_req, 32'h0);
      do_reset();
      chk(o_count, 32'h0);
      chk(o_cmp_pin, 32'h0);
      conclude();
   end
endmodule
